// file: hdl/afe_cfg_pkg.sv
// Purpose: Shared constants and types for the analog front end configuration registers.
// Assumes: Plain register port with 32-bit addresses and data.
// Notes: Offsets are full byte addresses on the peripheral bus.
package afe_cfg_pkg;

  localparam logic [31:0] IBUF_CTRL_ADDR = 32'h40083400;
  localparam logic [31:0] REF_CFG_ADDR = 32'h40087834;

  localparam logic [15:0] IBUF_CTRL_RESET = 16'h000F;
  localparam logic [7:0] REF_CFG_RESET = 8'h00;

  // Input buffer control field positions.
  localparam int AZ_DIS_BIT = 10;
  localparam int CHOP_POL_LSB = 8;
  localparam int CHOP_EN_LSB = 4;
  localparam int BUF_PD_LSB = 2;
  localparam int BUF_BYP_LSB = 0;
  // Reserved spans of the input buffer register are read-write storage too.
  localparam int IBUF_RSVD_HI_LSB = 11;
  localparam int IBUF_RSVD_MID_LSB = 6;

  // Reference configuration bit positions.
  localparam int DRV_A_PD_BIT = 6;
  localparam int EXT_REF_BIT = 3;
  localparam int DRV_B_PD_BIT = 2;
  localparam int REF_BUF_PD_BIT = 1;
  localparam int BG_PD_BIT = 0;
  localparam int REF_RSVD_HI_BIT = 7;
  localparam int REF_RSVD_MID_LSB = 4;

  // Two-bit side selectors: bit 1 is the P side, bit 0 the N side.
  typedef struct packed {
    logic autozero_disable;
    logic [1:0] manual_chop_polarity;
    logic [1:0] chop_enable;
    logic [1:0] buffer_power_down;
    logic [1:0] buffer_bypass;
  } ibuf_ctrl_type;

  typedef struct packed {
    logic out_driver_a_power_down;
    logic external_ref_select;
    logic out_driver_b_power_down;
    logic ref_buffer_power_down;
    logic bandgap_power_down;
  } ref_ctrl_type;

endpackage

// file: hdl/analog_front_end_config_regs.sv
// Purpose: Two configuration registers that drive static levels into the analog front end.
// Assumes: Software keeps the chop polarity field legal; the block does not police it.
// Notes: Reads have no side effects; unmapped addresses read as zero and ignore writes.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module analog_front_end_config_regs
  import afe_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [31:0] reg_rdata_o,
  // Analog control levels
  output ibuf_ctrl_type ibuf_ctrl_o,
  output ref_ctrl_type ref_ctrl_o
);

  // Both the write and the read path decode addresses, so each decode is one function.
  function automatic logic hits_ibuf(input logic [31:0] addr);
    return addr == IBUF_CTRL_ADDR;
  endfunction

  function automatic logic hits_ref(input logic [31:0] addr);
    return addr == REF_CFG_ADDR;
  endfunction

  // Writes to any other address miss both decodes and change nothing.
  logic ibuf_write;
  logic ref_write;

  assign ibuf_write = reg_write_i && hits_ibuf(reg_addr_i);
  assign ref_write = reg_write_i && hits_ref(reg_addr_i);

  // Reserved bits are read-write storage, so they are kept and read back.
  logic [4:0] ibuf_spare_hi_q;
  logic [4:0] ibuf_spare_hi_d;
  logic [1:0] ibuf_spare_mid_q;
  logic [1:0] ibuf_spare_mid_d;
  always_comb begin
    ibuf_spare_hi_d = ibuf_spare_hi_q;
    ibuf_spare_mid_d = ibuf_spare_mid_q;
    if (ibuf_write) begin
      ibuf_spare_hi_d = reg_wdata_i[IBUF_RSVD_HI_LSB +: 5];
      ibuf_spare_mid_d = reg_wdata_i[IBUF_RSVD_MID_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ibuf_spare_hi_q <= IBUF_CTRL_RESET[IBUF_RSVD_HI_LSB +: 5];
      ibuf_spare_mid_q <= IBUF_CTRL_RESET[IBUF_RSVD_MID_LSB +: 2];
    end else begin
      ibuf_spare_hi_q <= ibuf_spare_hi_d;
      ibuf_spare_mid_q <= ibuf_spare_mid_d;
    end
  end

  logic autozero_disable_q;
  logic autozero_disable_d;
  always_comb begin
    autozero_disable_d = autozero_disable_q;
    if (ibuf_write) begin
      autozero_disable_d = reg_wdata_i[AZ_DIS_BIT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      autozero_disable_q <= IBUF_CTRL_RESET[AZ_DIS_BIT];
    end else begin
      autozero_disable_q <= autozero_disable_d;
    end
  end

  // The polarity field is passed through as written; keeping it legal is up to software.
  logic [1:0] manual_chop_polarity_q;
  logic [1:0] manual_chop_polarity_d;
  always_comb begin
    manual_chop_polarity_d = manual_chop_polarity_q;
    if (ibuf_write) begin
      manual_chop_polarity_d = reg_wdata_i[CHOP_POL_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      manual_chop_polarity_q <= IBUF_CTRL_RESET[CHOP_POL_LSB +: 2];
    end else begin
      manual_chop_polarity_q <= manual_chop_polarity_d;
    end
  end

  logic [1:0] chop_enable_q;
  logic [1:0] chop_enable_d;
  always_comb begin
    chop_enable_d = chop_enable_q;
    if (ibuf_write) begin
      chop_enable_d = reg_wdata_i[CHOP_EN_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      chop_enable_q <= IBUF_CTRL_RESET[CHOP_EN_LSB +: 2];
    end else begin
      chop_enable_q <= chop_enable_d;
    end
  end

  logic [1:0] buffer_power_down_q;
  logic [1:0] buffer_power_down_d;
  always_comb begin
    buffer_power_down_d = buffer_power_down_q;
    if (ibuf_write) begin
      buffer_power_down_d = reg_wdata_i[BUF_PD_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      buffer_power_down_q <= IBUF_CTRL_RESET[BUF_PD_LSB +: 2];
    end else begin
      buffer_power_down_q <= buffer_power_down_d;
    end
  end

  logic [1:0] buffer_bypass_q;
  logic [1:0] buffer_bypass_d;
  always_comb begin
    buffer_bypass_d = buffer_bypass_q;
    if (ibuf_write) begin
      buffer_bypass_d = reg_wdata_i[BUF_BYP_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      buffer_bypass_q <= IBUF_CTRL_RESET[BUF_BYP_LSB +: 2];
    end else begin
      buffer_bypass_q <= buffer_bypass_d;
    end
  end

  logic ref_spare_hi_q;
  logic ref_spare_hi_d;
  logic [1:0] ref_spare_mid_q;
  logic [1:0] ref_spare_mid_d;
  always_comb begin
    ref_spare_hi_d = ref_spare_hi_q;
    ref_spare_mid_d = ref_spare_mid_q;
    if (ref_write) begin
      ref_spare_hi_d = reg_wdata_i[REF_RSVD_HI_BIT];
      ref_spare_mid_d = reg_wdata_i[REF_RSVD_MID_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ref_spare_hi_q <= REF_CFG_RESET[REF_RSVD_HI_BIT];
      ref_spare_mid_q <= REF_CFG_RESET[REF_RSVD_MID_LSB +: 2];
    end else begin
      ref_spare_hi_q <= ref_spare_hi_d;
      ref_spare_mid_q <= ref_spare_mid_d;
    end
  end

  logic out_driver_a_power_down_q;
  logic out_driver_a_power_down_d;
  always_comb begin
    out_driver_a_power_down_d = out_driver_a_power_down_q;
    if (ref_write) begin
      out_driver_a_power_down_d = reg_wdata_i[DRV_A_PD_BIT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      out_driver_a_power_down_q <= REF_CFG_RESET[DRV_A_PD_BIT];
    end else begin
      out_driver_a_power_down_q <= out_driver_a_power_down_d;
    end
  end

  logic external_ref_select_q;
  logic external_ref_select_d;
  always_comb begin
    external_ref_select_d = external_ref_select_q;
    if (ref_write) begin
      external_ref_select_d = reg_wdata_i[EXT_REF_BIT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      external_ref_select_q <= REF_CFG_RESET[EXT_REF_BIT];
    end else begin
      external_ref_select_q <= external_ref_select_d;
    end
  end

  logic out_driver_b_power_down_q;
  logic out_driver_b_power_down_d;
  always_comb begin
    out_driver_b_power_down_d = out_driver_b_power_down_q;
    if (ref_write) begin
      out_driver_b_power_down_d = reg_wdata_i[DRV_B_PD_BIT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      out_driver_b_power_down_q <= REF_CFG_RESET[DRV_B_PD_BIT];
    end else begin
      out_driver_b_power_down_q <= out_driver_b_power_down_d;
    end
  end

  logic ref_buffer_power_down_q;
  logic ref_buffer_power_down_d;
  always_comb begin
    ref_buffer_power_down_d = ref_buffer_power_down_q;
    if (ref_write) begin
      ref_buffer_power_down_d = reg_wdata_i[REF_BUF_PD_BIT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ref_buffer_power_down_q <= REF_CFG_RESET[REF_BUF_PD_BIT];
    end else begin
      ref_buffer_power_down_q <= ref_buffer_power_down_d;
    end
  end

  logic bandgap_power_down_q;
  logic bandgap_power_down_d;
  always_comb begin
    bandgap_power_down_d = bandgap_power_down_q;
    if (ref_write) begin
      bandgap_power_down_d = reg_wdata_i[BG_PD_BIT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bandgap_power_down_q <= REF_CFG_RESET[BG_PD_BIT];
    end else begin
      bandgap_power_down_q <= bandgap_power_down_d;
    end
  end

  // Readback images are rebuilt from the field flops, reserved spans included.
  logic [15:0] ibuf_image;
  logic [7:0] ref_image;
  always_comb begin
    ibuf_image = 16'h0000;
    ibuf_image[IBUF_RSVD_HI_LSB +: 5] = ibuf_spare_hi_q;
    ibuf_image[AZ_DIS_BIT] = autozero_disable_q;
    ibuf_image[CHOP_POL_LSB +: 2] = manual_chop_polarity_q;
    ibuf_image[IBUF_RSVD_MID_LSB +: 2] = ibuf_spare_mid_q;
    ibuf_image[CHOP_EN_LSB +: 2] = chop_enable_q;
    ibuf_image[BUF_PD_LSB +: 2] = buffer_power_down_q;
    ibuf_image[BUF_BYP_LSB +: 2] = buffer_bypass_q;
    ref_image = 8'h00;
    ref_image[REF_RSVD_HI_BIT] = ref_spare_hi_q;
    ref_image[DRV_A_PD_BIT] = out_driver_a_power_down_q;
    ref_image[REF_RSVD_MID_LSB +: 2] = ref_spare_mid_q;
    ref_image[EXT_REF_BIT] = external_ref_select_q;
    ref_image[DRV_B_PD_BIT] = out_driver_b_power_down_q;
    ref_image[REF_BUF_PD_BIT] = ref_buffer_power_down_q;
    ref_image[BG_PD_BIT] = bandgap_power_down_q;
  end

  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  // The port reads zero outside the cycle after a read, so stale data never lingers.
  always_comb begin
    rdata_d = 32'h00000000;
    if (reg_read_i && hits_ibuf(reg_addr_i)) begin
      rdata_d = {16'h0000, ibuf_image};
    end
    if (reg_read_i && hits_ref(reg_addr_i)) begin
      rdata_d = {24'h000000, ref_image};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // Levels go straight from the field flops so the analog side never sees a glitch.
  assign ibuf_ctrl_o.autozero_disable = autozero_disable_q;
  assign ibuf_ctrl_o.manual_chop_polarity = manual_chop_polarity_q;
  assign ibuf_ctrl_o.chop_enable = chop_enable_q;
  assign ibuf_ctrl_o.buffer_power_down = buffer_power_down_q;
  assign ibuf_ctrl_o.buffer_bypass = buffer_bypass_q;

  assign ref_ctrl_o.out_driver_a_power_down = out_driver_a_power_down_q;
  assign ref_ctrl_o.external_ref_select = external_ref_select_q;
  assign ref_ctrl_o.out_driver_b_power_down = out_driver_b_power_down_q;
  assign ref_ctrl_o.ref_buffer_power_down = ref_buffer_power_down_q;
  assign ref_ctrl_o.bandgap_power_down = bandgap_power_down_q;

endmodule

// file: verif/afe_cfg_chk.sv
// Purpose: Port checks.
// Assumes: One clock.
// Notes: Bound below.
`timescale 1ns/1ps
module afe_cfg_chk
  import afe_cfg_pkg::*;
(
  input wire logic clk_sys_i, rst_n_i, reg_write_i, reg_read_i,
  input wire logic [31:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
  input wire ibuf_ctrl_type ibuf_ctrl_o,
  input wire ref_ctrl_type ref_ctrl_o
);
  wire [31:0] w = reg_wdata_i;
  wire [8:0] b = ibuf_ctrl_o;
  wire [4:0] f = ref_ctrl_o;
  wire i = reg_write_i && reg_addr_i == IBUF_CTRL_ADDR;
  wire r = reg_write_i && reg_addr_i == REF_CFG_ADDR;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_az; i |=> b[8] == $past(w[10]); endproperty
  a_az: assert property (p_az) else $error("az");
  property p_pl; i |=> b[7:6] == $past(w[9:8]); endproperty
  a_pl: assert property (p_pl) else $error("pl");
  property p_ch; i |=> b[5:4] == $past(w[5:4]); endproperty
  a_ch: assert property (p_ch) else $error("ch");
  property p_pd; i |=> b[3:0] == $past(w[3:0]); endproperty
  a_pd: assert property (p_pd) else $error("pd");
  property p_rf; r |=> f == {$past(w[6]), $past(w[3:0])}; endproperty
  a_rf: assert property (p_rf) else $error("rf");
  property p_rs; $rose(rst_n_i) |-> b == 9'h00F && f == 5'h00; endproperty
  a_rs: assert property (p_rs) else $error("rs");
  property p_hd; !(i || r) |=> $stable(b) && $stable(f); endproperty
  a_hd: assert property (p_hd) else $error("hd");
  property p_rz; !reg_read_i |=> reg_rdata_o == 32'h0; endproperty
  a_rz: assert property (p_rz) else $error("rz");
endmodule
bind analog_front_end_config_regs afe_cfg_chk i_chk (.*);

// file: verif/testbench.sv
// Purpose: Register bench.
// Assumes: Reads answer next cycle.
// Notes: Output levels are compared with the model after every read.
`timescale 1ns/1ps
module testbench;
  import afe_cfg_pkg::*;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t %h %h", $time, g, e); end end
  logic clk_sys_i = 0, rst_n_i = 0, reg_write_i = 0, reg_read_i = 0;
  logic [31:0] reg_addr_i = 32'h0, reg_wdata_i = 32'h0, reg_rdata_o, d;
  logic [31:0] m[3] = '{32'hF, 32'h0, 32'h0};
  ibuf_ctrl_type ibuf_ctrl_o;
  ref_ctrl_type ref_ctrl_o;
  int n_fail = 0, comparisons = 0, seed = 32'h29E72437, k;
  always #50 clk_sys_i = ~clk_sys_i;
  analog_front_end_config_regs i_analog_front_end_config_regs (.*);
  task final_report;
    $display("n_fail %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial #100000 begin
    n_fail++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    for (int i = 0; i < 45; i++) begin
      k = i % 3;
      @(posedge clk_sys_i) {rst_n_i, reg_write_i, reg_read_i} <= 3'h5;
      reg_addr_i <= k == 0 ? IBUF_CTRL_ADDR : k == 1 ? REF_CFG_ADDR : 32'h40083404;
      @(posedge clk_sys_i) reg_read_i <= 1'b0;
      #1 `CHK(reg_rdata_o, m[k])
      `CHK(ibuf_ctrl_o, {m[0][10:8], m[0][5:0]})
      `CHK(ref_ctrl_o, {m[1][6], m[1][3:0]})
      d = $random(seed);
      if (!d[10] || d[5:4] != 2'h0) d[9:8] = 2'h0;
      @(posedge clk_sys_i) {reg_write_i, reg_wdata_i} <= {1'b1, d};
      m[k] = d & (k == 0 ? 32'hFFFF : k == 1 ? 32'hFF : 32'h0);
    end
    final_report;
  end
endmodule
